// ### clkdiv_cfg_assertions.sv
// Port checker for the divider register bank
`timescale 1ns/1ps
`default_nettype none
module clkdiv_cfg_assertions (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic serialLatchStrobe,
    input wire logic extSyncPin,
    input wire logic extSlipPin,
    input wire logic [5:0] divideFactor,
    input wire logic ratioValid,
    input wire logic [2:0] syncTrimCode,
    input wire logic pinSyncEnable,
    input wire logic pinSlipEnable,
    input wire logic dividerHoldReset,
    input wire logic syncRequest,
    input wire logic slipRequest,
    input wire logic launchLate,
    input wire logic [5:0] fineDelayCode
);
    // Single domain
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    ////////////////////
    reset_values_a: assert property ($rose(arst_n) |-> divideFactor == 6'h04 &&
        syncTrimCode == 3'h3 && fineDelayCode == 6'h04 && !launchLate && !dividerHoldReset)
        else $error("settings wrong after reset");
    ratio_onehot_a: assert property (ratioValid |-> $onehot(divideFactor))
        else $error("valid ratio not one-hot");
    ratio_zero_a: assert property (!ratioValid |-> divideFactor == 6'h00)
        else $error("bad factor");
    sync_pin_a: assert property ($rose(extSyncPin) && pinSyncEnable |-> ##[1:6] syncRequest)
        else $error("sync pin ignored");
    slip_pin_a: assert property ($rose(extSlipPin) && pinSlipEnable |-> ##[1:6] slipRequest)
        else $error("slip pin ignored");
    sync_start_a: assert property ($fell(dividerHoldReset) |-> ##[0:3] syncRequest)
        else $error("no start");
    slip_single_a: assert property (slipRequest |=> !slipRequest)
        else $error("slip pulse too long");
    // Settings move only after a latch
    fine_move_a: assert property ($changed(fineDelayCode) |->
        $past(serialLatchStrobe) || $past(serialLatchStrobe, 2)) else $error("delay moved");
    launch_move_a: assert property ($changed(launchLate) |->
        $past(serialLatchStrobe) || $past(serialLatchStrobe, 2)) else $error("launch moved");
endmodule
`default_nettype wire
bind clock_divider_control_regs clkdiv_cfg_assertions sva_inst (
    .mclk(mclk), .arst_n(arst_n), .serialLatchStrobe(serialLatchStrobe),
    .extSyncPin(extSyncPin), .extSlipPin(extSlipPin), .divideFactor(divideFactor),
    .ratioValid(ratioValid), .syncTrimCode(syncTrimCode), .pinSyncEnable(pinSyncEnable),
    .pinSlipEnable(pinSlipEnable), .dividerHoldReset(dividerHoldReset),
    .syncRequest(syncRequest), .slipRequest(slipRequest), .launchLate(launchLate),
    .fineDelayCode(fineDelayCode));

// ### clkdiv_cfg_pkg.sv
// Constants shared by the clock divider configuration register bank
//
// Functional notes
// - Register 0 low nibble selects readback register
// - Reading register 0 returns 9-bit part identifier
// - Register 1 bit 2 enables divider core
// - Register 1 bit 3 enables output buffer
// - Ratio codes 0-5 divide by 1 to 32
// - Register 3 bits 8:6 trim sync delay
// - Broadcast bit accepts writes to chip address 111
// - Register 4 bit 1 lets sync pin start divider
// - Register 4 bit 2 lets pin request slip
// - Register 4 bit 4 selects fine delay path
// - Register 5 code selects general output source
// - Register 5 bit 3 keeps pin on general output
// - Register 5 bit 4 dedicates pin to readback
// - Register 5 bit 5 floats the output pin
// - Register 6 bit 0 low holds divider reset
// - Rising slip bit slips one input cycle
// - Register 6 bit 2 selects late launch edge
// - Register 7 holds six-bit fine delay setpoint
// - Readback of selected register in next transfer
package clkdiv_cfg_pkg;
    // Frame geometry: 9 data, 4 register address, 3 chip address bits
    localparam int REG_W = 9;
    localparam int REG_ADDR_W = 4;
    localparam int CHIP_ADDR_W = 3;
    localparam int FRAME_W = 16;
    localparam int REG_COUNT = 8;
    localparam int DATA_LSB = 7;
    localparam int RADDR_LSB = 3;
    localparam logic [CHIP_ADDR_W-1:0] BROADCAST_ADDR = 3'h7;
    // Arbitrary identifier value, not tied to any real part
    localparam logic [REG_W-1:0] CHIP_ID_DEFAULT = 9'h0a5;
    // Register indices
    localparam logic [REG_ADDR_W-1:0] IDX_ID_RDSEL = 4'h0;
    localparam logic [REG_ADDR_W-1:0] IDX_ENABLES = 4'h1;
    localparam logic [REG_ADDR_W-1:0] IDX_RATIO = 4'h2;
    localparam logic [REG_ADDR_W-1:0] IDX_BIAS = 4'h3;
    localparam logic [REG_ADDR_W-1:0] IDX_CONFIG = 4'h4;
    localparam logic [REG_ADDR_W-1:0] IDX_GPOUT = 4'h5;
    localparam logic [REG_ADDR_W-1:0] IDX_TRIGGERS = 4'h6;
    localparam logic [REG_ADDR_W-1:0] IDX_FINE_DELAY = 4'h7;
    // Reset values per register
    localparam logic [REG_W-1:0] RST_ID_RDSEL = 9'h000;
    localparam logic [REG_W-1:0] RST_ENABLES = 9'h00f;
    localparam logic [REG_W-1:0] RST_RATIO = 9'h002;
    localparam logic [REG_W-1:0] RST_BIAS = 9'h0ea;
    localparam logic [REG_W-1:0] RST_CONFIG = 9'h002;
    localparam logic [REG_W-1:0] RST_GPOUT = 9'h000;
    localparam logic [REG_W-1:0] RST_TRIGGERS = 9'h001;
    localparam logic [REG_W-1:0] RST_FINE_DELAY = 9'h004;
    // Writable bit masks; everything else is reserved
    localparam logic [REG_W-1:0] MASK_ID_RDSEL = 9'h00f;
    localparam logic [REG_W-1:0] MASK_ENABLES = 9'h00f;
    localparam logic [REG_W-1:0] MASK_RATIO = 9'h007;
    localparam logic [REG_W-1:0] MASK_BIAS = 9'h1ff;
    localparam logic [REG_W-1:0] MASK_CONFIG = 9'h03f;
    localparam logic [REG_W-1:0] MASK_GPOUT = 9'h03f;
    localparam logic [REG_W-1:0] MASK_TRIGGERS = 9'h007;
    localparam logic [REG_W-1:0] MASK_FINE_DELAY = 9'h03f;
    // Field positions
    localparam int POS_SOFT_RESET = 4;
    localparam int POS_MASTER_EN = 0;
    localparam int POS_RX_EN = 1;
    localparam int POS_CORE_EN = 2;
    localparam int POS_OUTBUF_EN = 3;
    localparam int POS_SWING_LSB = 4;
    localparam int POS_SYNC_TRIM_LSB = 6;
    localparam int POS_BROADCAST = 0;
    localparam int POS_PIN_SYNC_EN = 1;
    localparam int POS_PIN_SLIP_EN = 2;
    localparam int POS_RX_DC_BIAS = 3;
    localparam int POS_DELAY_LINE_EN = 4;
    localparam int POS_REG_BYPASS = 5;
    localparam int POS_FORCE_GP = 3;
    localparam int POS_FORCE_RB = 4;
    localparam int POS_HIGH_IMPEDANCE = 5;
    localparam int POS_SYNC_RUN = 0;
    localparam int POS_SLIP_TRIG = 1;
    localparam int POS_LAUNCH_LATE = 2;
    // Highest valid divide ratio code
    localparam logic [2:0] RATIO_CODE_MAX = 3'h5;
    // General output source codes
    localparam logic [2:0] GP_ZERO = 3'h0;
    localparam logic [2:0] GP_ONE = 3'h1;
    localparam logic [2:0] GP_SLIP = 3'h2;
    localparam logic [2:0] GP_ZERO_B = 3'h3;
    localparam logic [2:0] GP_SYNC = 3'h4;
    localparam logic [2:0] GP_SYNC_DLY = 3'h5;
    localparam logic [2:0] GP_WAIT_CLK = 3'h6;
    localparam logic [2:0] GP_SPARE = 3'h7;
endpackage

// ### clock_divider_control_regs.sv
// Configuration register bank of the programmable clock divider
`timescale 1ns/1ps
`default_nettype none
module clock_divider_control_regs #(
    // Identifier returned by register 0; value is arbitrary
    parameter logic [8:0] CHIP_ID = clkdiv_cfg_pkg::CHIP_ID_DEFAULT
) (
    input wire logic mclk,
    input wire logic arst_n,
    // Serial port
    input wire logic sclk,
    input wire logic sdi,
    input wire logic serialLatchStrobe,
    // Own chip address, strapped on pins
    input wire logic [2:0] chipAddrStrap,
    // External trigger pins
    input wire logic extSyncPin,
    input wire logic extSlipPin,
    // Status from the divider core
    input wire logic syncDelayedStatus,
    input wire logic waitClockStatus,
    // Shared general output / readback pin
    output logic auxOutputPinOut,
    output logic auxOutputPinOe,
    // Enables
    output logic masterChipEnable,
    output logic rxBufferEnable,
    output logic dividerCoreEnable,
    output logic outputBufferEnable,
    // Divider setup
    output logic [5:0] divideFactor,
    output logic ratioValid,
    output logic [1:0] swingSelect,
    output logic [2:0] syncTrimCode,
    // Configuration
    output logic pinSyncEnable,
    output logic pinSlipEnable,
    output logic rxDcBiasSelect,
    output logic delayLineEnable,
    output logic regulatorBypass,
    // Triggers
    output logic dividerHoldReset,
    output logic syncRequest,
    output logic slipRequest,
    output logic launchLate,
    // Fine delay
    output logic [5:0] fineDelayCode
);
    localparam int W = clkdiv_cfg_pkg::REG_W;

    ////////////////////////////////////////////////////////////////////
    // Helper functions

    // Reset value of each register, used at reset and at soft reset
    function automatic logic [W-1:0] resetValue(input int idx);
        logic [W-1:0] v;
        v = '0;
        case (idx)
            0: v = clkdiv_cfg_pkg::RST_ID_RDSEL;
            1: v = clkdiv_cfg_pkg::RST_ENABLES;
            2: v = clkdiv_cfg_pkg::RST_RATIO;
            3: v = clkdiv_cfg_pkg::RST_BIAS;
            4: v = clkdiv_cfg_pkg::RST_CONFIG;
            5: v = clkdiv_cfg_pkg::RST_GPOUT;
            6: v = clkdiv_cfg_pkg::RST_TRIGGERS;
            7: v = clkdiv_cfg_pkg::RST_FINE_DELAY;
            default: v = '0;
        endcase
        return v;
    endfunction

    // Writable bits of each register
    function automatic logic [W-1:0] writeMask(input logic [3:0] idx);
        logic [W-1:0] m;
        m = '0;
        case (idx)
            clkdiv_cfg_pkg::IDX_ID_RDSEL: m = clkdiv_cfg_pkg::MASK_ID_RDSEL;
            clkdiv_cfg_pkg::IDX_ENABLES: m = clkdiv_cfg_pkg::MASK_ENABLES;
            clkdiv_cfg_pkg::IDX_RATIO: m = clkdiv_cfg_pkg::MASK_RATIO;
            clkdiv_cfg_pkg::IDX_BIAS: m = clkdiv_cfg_pkg::MASK_BIAS;
            clkdiv_cfg_pkg::IDX_CONFIG: m = clkdiv_cfg_pkg::MASK_CONFIG;
            clkdiv_cfg_pkg::IDX_GPOUT: m = clkdiv_cfg_pkg::MASK_GPOUT;
            clkdiv_cfg_pkg::IDX_TRIGGERS: m = clkdiv_cfg_pkg::MASK_TRIGGERS;
            clkdiv_cfg_pkg::IDX_FINE_DELAY: m = clkdiv_cfg_pkg::MASK_FINE_DELAY;
            default: m = '0;
        endcase
        return m;
    endfunction

    // Ratio code to one-hot division factor; invalid codes give zero
    function automatic logic [5:0] ratioDecode(input logic [2:0] code);
        logic [5:0] f;
        f = '0;
        if (code <= clkdiv_cfg_pkg::RATIO_CODE_MAX) begin
            f = 6'h01 << code;
        end
        return f;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Serial shifter

    serial_frame_if frm ();

    serial_frame_shifter u_shifter (
        .mclk(mclk),
        .arst_n(arst_n),
        .sclk(sclk),
        .sdi(sdi),
        .serialLatchStrobe(serialLatchStrobe),
        .frm(frm)
    );

    ////////////////////////////////////////////////////////////////////
    // Address decode

    // Eight registers; masking keeps reserved bits zero
    logic [W-1:0] regFile_r [clkdiv_cfg_pkg::REG_COUNT];
    logic addrHit; // Frame names this chip
    logic bcastHit; // Broadcast frame accepted
    logic wrAccept; // Latch edge of a frame meant for us
    logic softReset; // Write of the soft reset bit to register 0

    assign addrHit = frm.wrChip == chipAddrStrap;
    // Broadcast address is only honoured while the broadcast bit is set
    assign bcastHit = regFile_r[4][clkdiv_cfg_pkg::POS_BROADCAST]
        && (frm.wrChip == clkdiv_cfg_pkg::BROADCAST_ADDR);
    assign wrAccept = frm.frameDone && (addrHit || bcastHit);
    assign softReset = wrAccept && (frm.wrReg == clkdiv_cfg_pkg::IDX_ID_RDSEL)
        && frm.wrData[clkdiv_cfg_pkg::POS_SOFT_RESET];

    ////////////////////////////////////////////////////////////////////
    // Register file

    // Writes land on the latch strobe rising edge. The soft reset bit
    // is not stored: it restores every register in the same edge, so
    // a frame cannot leave the bank half-reset.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < clkdiv_cfg_pkg::REG_COUNT; i++) begin
                regFile_r[i] <= resetValue(i);
            end
        end else if (softReset) begin
            for (int i = 0; i < clkdiv_cfg_pkg::REG_COUNT; i++) begin
                regFile_r[i] <= resetValue(i);
            end
        end else if (wrAccept && (frm.wrReg < 4'(clkdiv_cfg_pkg::REG_COUNT))) begin
            // Masking drops reserved and read-only bits
            regFile_r[frm.wrReg[2:0]] <= frm.wrData & writeMask(frm.wrReg);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Readback path

    logic [3:0] readSel; // Register chosen for the next transfer
    logic [W-1:0] readValue; // Its current contents
    logic [clkdiv_cfg_pkg::FRAME_W-1:0] rbShift_r; // Outgoing readback word
    logic sdoBit_r; // Bit currently presented
    logic addrOk_r; // Last latched frame named this chip

    assign readSel = regFile_r[0][3:0];

    // Register 0 answers with the identifier, not its own contents
    always_comb begin
        readValue = '0;
        if (readSel == clkdiv_cfg_pkg::IDX_ID_RDSEL) begin
            readValue = CHIP_ID;
        end else if (readSel < 4'(clkdiv_cfg_pkg::REG_COUNT)) begin
            readValue = regFile_r[readSel[2:0]];
        end else begin
            // Unmapped addresses read zero
            readValue = '0;
        end
    end

    // Word is captured when the strobe falls, so a select written in
    // one frame is returned during the following one.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rbShift_r <= '0;
            sdoBit_r <= 1'b0;
        end else if (frm.frameStart) begin
            rbShift_r <= {readValue, 7'h00};
        end else if (frm.bitTick) begin
            // One bit per serial clock rising edge, MSB first
            sdoBit_r <= rbShift_r[clkdiv_cfg_pkg::FRAME_W-1];
            rbShift_r <= {rbShift_r[clkdiv_cfg_pkg::FRAME_W-2:0], 1'b0};
        end
    end

    // A foreign chip address floats readback to avoid bus contention
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            addrOk_r <= 1'b1;
        end else if (frm.frameDone) begin
            addrOk_r <= addrHit;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Trigger edge detection

    logic slipBitPrev_r; // Slip trigger bit one cycle ago
    logic syncBitPrev_r; // Sync run bit one cycle ago
    logic extSlipPrev_r; // Slip pin one cycle ago
    logic extSyncPrev_r; // Sync pin one cycle ago
    logic slipReq_r; // One-cycle slip pulse
    logic syncReq_r; // One-cycle sync pulse
    logic slipBit;
    logic syncBit;

    assign slipBit = regFile_r[6][clkdiv_cfg_pkg::POS_SLIP_TRIG];
    assign syncBit = regFile_r[6][clkdiv_cfg_pkg::POS_SYNC_RUN];

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            slipBitPrev_r <= 1'b0;
            syncBitPrev_r <= 1'b1;
            extSlipPrev_r <= 1'b0;
            extSyncPrev_r <= 1'b0;
        end else begin
            slipBitPrev_r <= slipBit;
            syncBitPrev_r <= syncBit;
            extSlipPrev_r <= extSlipPin;
            extSyncPrev_r <= extSyncPin;
        end
    end

    // Only the 0-to-1 change slips, so a held bit slips once; the
    // host must write the bit low again before it can slip again.
    // Both pin enables set at once is a host error; each pin then
    // acts on its own path and the results are not defined.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            slipReq_r <= 1'b0;
            syncReq_r <= 1'b0;
        end else begin
            slipReq_r <= (slipBit && !slipBitPrev_r)
                || (pinSlipEnable && extSlipPin && !extSlipPrev_r);
            syncReq_r <= (syncBit && !syncBitPrev_r)
                || (pinSyncEnable && extSyncPin && !extSyncPrev_r);
        end
    end

    assign slipRequest = slipReq_r;
    assign syncRequest = syncReq_r;

    ////////////////////////////////////////////////////////////////////
    // Control outputs, straight from register flops

    assign masterChipEnable = regFile_r[1][clkdiv_cfg_pkg::POS_MASTER_EN];
    assign rxBufferEnable = regFile_r[1][clkdiv_cfg_pkg::POS_RX_EN];
    assign dividerCoreEnable = regFile_r[1][clkdiv_cfg_pkg::POS_CORE_EN];
    assign outputBufferEnable = regFile_r[1][clkdiv_cfg_pkg::POS_OUTBUF_EN];
    assign swingSelect = regFile_r[3][clkdiv_cfg_pkg::POS_SWING_LSB +: 2];
    // Delay is 1000 ps plus 80 ps per code in the analog path
    assign syncTrimCode = regFile_r[3][clkdiv_cfg_pkg::POS_SYNC_TRIM_LSB +: 3];
    assign pinSyncEnable = regFile_r[4][clkdiv_cfg_pkg::POS_PIN_SYNC_EN];
    assign pinSlipEnable = regFile_r[4][clkdiv_cfg_pkg::POS_PIN_SLIP_EN];
    assign rxDcBiasSelect = regFile_r[4][clkdiv_cfg_pkg::POS_RX_DC_BIAS];
    assign delayLineEnable = regFile_r[4][clkdiv_cfg_pkg::POS_DELAY_LINE_EN];
    assign regulatorBypass = regFile_r[4][clkdiv_cfg_pkg::POS_REG_BYPASS];
    // Divider held in reset while the run bit is low
    assign dividerHoldReset = ~syncBit;
    // Going back to early launch needs host-driven slips first
    assign launchLate = regFile_r[6][clkdiv_cfg_pkg::POS_LAUNCH_LATE];
    // Delay is 300 ps plus 20 ps per setpoint step in the analog path
    assign fineDelayCode = regFile_r[7][5:0];

    // Ratio decode registered so the core sees a clean factor
    logic [5:0] divideFactor_r; // One-hot factor
    logic ratioValid_r; // Code in 0..5

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            divideFactor_r <= 6'h04;
            ratioValid_r <= 1'b1;
        end else begin
            divideFactor_r <= ratioDecode(regFile_r[2][2:0]);
            ratioValid_r <= regFile_r[2][2:0] <= clkdiv_cfg_pkg::RATIO_CODE_MAX;
        end
    end

    assign divideFactor = divideFactor_r;
    assign ratioValid = ratioValid_r;

    ////////////////////////////////////////////////////////////////////
    // General output selection and shared pin steering

    logic [2:0] gpSel;
    logic gpValue; // Selected general output level
    logic pinOut_r; // Registered pin level
    logic pinOe_r; // Registered pin drive enable

    assign gpSel = regFile_r[5][2:0];

    always_comb begin
        gpValue = 1'b0;
        case (gpSel)
            clkdiv_cfg_pkg::GP_ZERO: gpValue = 1'b0;
            clkdiv_cfg_pkg::GP_ONE: gpValue = 1'b1;
            clkdiv_cfg_pkg::GP_SLIP: gpValue = slipReq_r;
            clkdiv_cfg_pkg::GP_ZERO_B: gpValue = 1'b0;
            clkdiv_cfg_pkg::GP_SYNC: gpValue = syncReq_r;
            clkdiv_cfg_pkg::GP_SYNC_DLY: gpValue = syncDelayedStatus;
            clkdiv_cfg_pkg::GP_WAIT_CLK: gpValue = waitClockStatus;
            // Spare code drives low rather than leaving the pin floating
            clkdiv_cfg_pkg::GP_SPARE: gpValue = 1'b0;
            default: gpValue = 1'b0;
        endcase
    end

    // Priority: float, then readback only, then general only, then
    // automatic sharing with readback while a frame is shifting.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pinOut_r <= 1'b0;
            pinOe_r <= 1'b1;
        end else if (regFile_r[5][clkdiv_cfg_pkg::POS_HIGH_IMPEDANCE]) begin
            pinOut_r <= 1'b0;
            pinOe_r <= 1'b0;
        end else if (regFile_r[5][clkdiv_cfg_pkg::POS_FORCE_RB]) begin
            pinOut_r <= sdoBit_r;
            pinOe_r <= addrOk_r;
        end else if (regFile_r[5][clkdiv_cfg_pkg::POS_FORCE_GP]) begin
            pinOut_r <= gpValue;
            pinOe_r <= 1'b1;
        end else if (frm.inFrame) begin
            // Shared mode during a transfer: readback data
            pinOut_r <= sdoBit_r;
            pinOe_r <= addrOk_r;
        end else begin
            // Shared mode between transfers: general output
            pinOut_r <= gpValue;
            pinOe_r <= 1'b1;
        end
    end

    assign auxOutputPinOut = pinOut_r;
    assign auxOutputPinOe = pinOe_r;
endmodule
`default_nettype wire

// ### serial_frame_if.sv
// Frame events passed from the serial shifter to the register bank
`timescale 1ns/1ps
`default_nettype none
interface serial_frame_if;
    logic bitTick; // Serial clock rising edge while latch strobe is low
    logic frameDone; // Latch strobe rising edge
    logic frameStart; // Latch strobe falling edge
    logic inFrame; // Bits shifting since last latch
    logic [8:0] wrData; // Received data field
    logic [3:0] wrReg; // Received register address field
    logic [2:0] wrChip; // Received chip address field
    modport shifter (output bitTick, frameDone, frameStart, inFrame, wrData, wrReg, wrChip);
    modport bank (input bitTick, frameDone, frameStart, inFrame, wrData, wrReg, wrChip);
endinterface
`default_nettype wire

// ### serial_frame_shifter.sv
// Serial port shifter: samples the three-wire port and frames words
`timescale 1ns/1ps
`default_nettype none
module serial_frame_shifter (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic serialLatchStrobe,
    serial_frame_if.shifter frm
);
    logic sclkPrev_r; // Serial clock one sample ago
    logic slePrev_r; // Latch strobe one sample ago
    logic [clkdiv_cfg_pkg::FRAME_W-1:0] shift_r; // Last sixteen bits seen
    logic inFrame_r; // Shifting in progress
    logic sclkRise;
    logic sleRise;

    ////////////////////////////////////////////////////////////////////
    // Edge sampling; pins are already synchronous to mclk
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sclkPrev_r <= 1'b0;
            slePrev_r <= 1'b0;
        end else begin
            sclkPrev_r <= sclk;
            slePrev_r <= serialLatchStrobe;
        end
    end

    assign sclkRise = sclk & ~sclkPrev_r;
    assign sleRise = serialLatchStrobe & ~slePrev_r;

    // Shift MSB first; only the last sixteen bits matter at the latch
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            shift_r <= '0;
        end else if (sclkRise && !serialLatchStrobe) begin
            shift_r <= {shift_r[clkdiv_cfg_pkg::FRAME_W-2:0], sdi};
        end
    end

    // Frame activity flag, steers the shared output pin
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            inFrame_r <= 1'b0;
        end else if (sleRise) begin
            inFrame_r <= 1'b0;
        end else if (sclkRise && !serialLatchStrobe) begin
            inFrame_r <= 1'b1;
        end
    end

    assign frm.bitTick = sclkRise & ~serialLatchStrobe;
    assign frm.frameDone = sleRise;
    assign frm.frameStart = ~serialLatchStrobe & slePrev_r;
    assign frm.inFrame = inFrame_r;
    assign frm.wrData = shift_r[clkdiv_cfg_pkg::FRAME_W-1:clkdiv_cfg_pkg::DATA_LSB];
    assign frm.wrReg = shift_r[clkdiv_cfg_pkg::DATA_LSB-1:clkdiv_cfg_pkg::RADDR_LSB];
    assign frm.wrChip = shift_r[clkdiv_cfg_pkg::RADDR_LSB-1:0];
endmodule
`default_nettype wire

// ### serial_host_model.sv
// Serial port master model
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
    input wire logic mclk,
    input wire logic pinLevel,
    output logic sclk,
    output logic sdi,
    output logic serialLatchStrobe
);
    // Idle levels
    initial begin
        sclk = 1'b0;
        sdi = 1'b0;
        serialLatchStrobe = 1'b0;
    end
    // Each level holds four edges
    task automatic pause();
        repeat (4) @(posedge mclk);
        #1;
    endtask
    // One frame, MSB first
    task automatic xfer(input logic [15:0] w, output logic [15:0] rd);
        for (int i = 15; i >= 0; i--) begin
            sdi = w[i];
            pause();
            sclk = 1'b1;
            pause();
            rd[i] = pinLevel;
            sclk = 1'b0;
        end
        pause();
        serialLatchStrobe = 1'b1;
        pause();
        serialLatchStrobe = 1'b0;
        sdi = ~sdi; // No stale bit
        pause();
    endtask
endmodule
`default_nettype wire

// ### tb_top.sv
// Bench for the divider register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic mclk, arst_n, sclk, sdi, stb, syncPin, slipPin, stat, pinOut, pinOe, core, obuf, dly;
    logic ratioOk, late;
    logic [5:0] factor, fine;
    logic [2:0] trim, own;
    logic [8:0] expReg [8];
    logic [15:0] rd;
    logic [31:0] seed = 32'hd2a8b4ff;
    int n_mismatch = 0, tests_run = 0, cyc = 0;
    // Writable bits; register 0 entry kept zero as it reads the identifier
    logic [8:0] msk [8] = '{9'h0, 9'h00f, 9'h007, 9'h1ff, 9'h03f, 9'h03f, 9'h007, 9'h03f};
    wire logic pinLevel = pinOe ? pinOut : 1'b0; // Pull-down when released
    clock_divider_control_regs clock_divider_control_regs_inst (.mclk(mclk), .arst_n(arst_n),
        .sclk(sclk), .sdi(sdi), .serialLatchStrobe(stb), .chipAddrStrap(own),
        .extSyncPin(syncPin), .extSlipPin(slipPin), .syncDelayedStatus(stat),
        .waitClockStatus(stat), .auxOutputPinOut(pinOut), .auxOutputPinOe(pinOe),
        .masterChipEnable(), .rxBufferEnable(), .dividerCoreEnable(core),
        .outputBufferEnable(obuf), .divideFactor(factor), .ratioValid(ratioOk),
        .swingSelect(), .syncTrimCode(trim), .pinSyncEnable(), .pinSlipEnable(),
        .rxDcBiasSelect(), .delayLineEnable(dly), .regulatorBypass(),
        .dividerHoldReset(), .syncRequest(), .slipRequest(), .launchLate(late),
        .fineDelayCode(fine));
    serial_host_model serial_host_model_inst (.mclk(mclk), .pinLevel(pinLevel), .sclk(sclk),
        .sdi(sdi), .serialLatchStrobe(stb));
    ////////////////////
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // Hang guard
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 60000) begin
            n_mismatch++;
            conclude();
        end
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] want);
        tests_run++;
        if (got !== want) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    // Write; only own-chip frames update expReg
    task automatic wr(input logic [3:0] r, input logic [8:0] d, input logic [2:0] c);
        serial_host_model_inst.xfer({d, r, c}, rd);
        if (c == own && r < 4'h8) expReg[r[2:0]] = d & msk[r[2:0]];
    endtask
    // Select, then read back
    task automatic rdchk(input logic [3:0] r);
        wr(4'h0, {5'h0, r}, own);
        serial_host_model_inst.xfer({5'h0, r, 4'h0, own}, rd);
        chk(rd, {r == 4'h0 ? 9'h0a5 : r > 4'h7 ? 9'h0 : expReg[r[2:0]], 7'h0});
    endtask
    task automatic conclude();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    ////////////////////
    initial begin
        {arst_n, syncPin, slipPin, stat} = 4'h0;
        own = 3'(xs() % 7);
        expReg = '{9'h0, 9'h00f, 9'h002, 9'h0ea, 9'h002, 9'h000, 9'h001, 9'h004};
        repeat (12) @(posedge mclk);
        #1 arst_n = 1'b1;
        for (int r = 0; r < 10; r++) rdchk(4'(r));
        wr(4'h7, 9'h03f, own + 3'h1);
        wr(4'h4, 9'h003, own);
        wr(4'h7, 9'h1d5, 3'h7);
        expReg[7] = 9'h015;
        rdchk(4'h7);
        for (int i = 0; i < 24; i++) begin
            logic [3:0] r;
            logic [8:0] d;
            r = 4'(xs() % 7 + 1);
            d = 9'(xs());
            if (r == 4'h5) d &= 9'h007;
            if (d[1]) d[2] = 1'b0;
            wr(r, d, own);
            rdchk(r);
            chk({obuf, core, dly, late, trim, fine}, {expReg[1][3:2], expReg[4][4],
                expReg[6][2], expReg[3][8:6], expReg[7][5:0]});
            chk({ratioOk, factor}, expReg[2][2:0] < 3'h6 ? {1'b1, 6'h01 << expReg[2][2:0]} : 0);
        end
        for (int k = 1; k < 3; k++) begin
            wr(4'h4, 9'(k << 1), own);
            @(posedge mclk) #1 {slipPin, syncPin} = 2'(k);
            repeat (8) @(posedge mclk);
            #1 {slipPin, syncPin} = 2'h0;
        end
        wr(4'h6, 9'h000, own);
        wr(4'h6, 9'h003, own);
        stat = 1'b1;
        for (int c = 0; c < 8; c++) begin
            wr(4'h5, 9'(8 + c), own);
            chk(pinOut, c == 1 || c == 5 || c == 6);
        end
        wr(4'h5, 9'h020, own);
        chk(pinOe, 1'b0);
        conclude();
    end
endmodule
`default_nettype wire
